// *** rtl/tcad_pkg.sv ***
// holds the constants and types shared by the core and its arithmetic unit
// assumes a single core clock where one clock_in period is one instruction cycle
package tcad_pkg;
   // ****************************************
   // widths
   // ****************************************
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 5;
   localparam int STACK_DEPTH = 2;
   localparam int OSC_PER_INSTR = 4; // oscillator periods in one instruction cycle
   // ****************************************
   // file addresses handled inside the core
   // ****************************************
   localparam logic [4:0] ADDR_INDIRECT = 5'h00;
   localparam logic [4:0] ADDR_PCL = 5'h02;
   localparam logic [4:0] ADDR_STATUS = 5'h03;
   localparam logic [4:0] ADDR_FSR = 5'h04;
   // ****************************************
   // status layout and reset values
   // ****************************************
   localparam int STATUS_C = 0;
   localparam int STATUS_DIGIT = 1;
   localparam int STATUS_Z = 2;
   localparam logic [7:0] STATUS_RESET = 8'h18;
   localparam logic [7:0] STATUS_RO_MASK = 8'h18; // power-down and timeout bits
   localparam logic [2:0] FSR_UPPER_READ = 3'h7;
   localparam logic [4:0] FSR_RESET = 5'h00;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [11:0] NOP_WORD = 12'h000;

   typedef enum logic [3:0] {
      TCAD_ADD, TCAD_SUB, TCAD_AND, TCAD_OR, TCAD_XOR, TCAD_PASS_A, TCAD_PASS_B,
      TCAD_COM, TCAD_INC, TCAD_DEC, TCAD_RR, TCAD_RL, TCAD_SWAP, TCAD_ZERO
   } tcad_alu_op_type;
endpackage

// *** rtl/tcad_alu.sv ***
// holds the 8-bit arithmetic and logic unit of the core
// assumes operand a is the working register side and b the file or literal side
`timescale 1ns/1ps
module tcad_alu
   import tcad_pkg::*;
(
   input wire tcad_pkg::tcad_alu_op_type op_in,
   input wire logic [tcad_pkg::DATA_W-1:0] a_in,
   input wire logic [tcad_pkg::DATA_W-1:0] b_in,
   input wire logic carry_in,
   output logic [tcad_pkg::DATA_W-1:0] result_out,
   output logic carry_out,
   output logic digit_carry_out,
   output logic zero_out
);
   import tcad_pkg::*;

   // ****************************************
   // operation select
   // ****************************************
   logic [8:0] wide;
   logic [4:0] nib;

   // two's complement add and subtract; carry means no borrow on subtract
   always_comb begin
      wide = 9'h000;
      nib = 5'h00;
      result_out = b_in;
      carry_out = carry_in;
      digit_carry_out = 1'b0;
      unique case (op_in)
         TCAD_ADD: begin
            wide = {1'b0, a_in} + {1'b0, b_in};
            nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]};
            result_out = wide[7:0];
            carry_out = wide[8];
            digit_carry_out = nib[4];
         end
         TCAD_SUB: begin // b minus a
            wide = {1'b0, b_in} + {1'b0, ~a_in} + 9'h001;
            nib = {1'b0, b_in[3:0]} + {1'b0, ~a_in[3:0]} + 5'h01;
            result_out = wide[7:0];
            carry_out = wide[8];
            digit_carry_out = nib[4];
         end
         TCAD_AND: result_out = a_in & b_in;
         TCAD_OR: result_out = a_in | b_in;
         TCAD_XOR: result_out = a_in ^ b_in;
         TCAD_PASS_A: result_out = a_in;
         TCAD_PASS_B: result_out = b_in;
         TCAD_COM: result_out = ~b_in;
         TCAD_INC: result_out = b_in + 8'h01;
         TCAD_DEC: result_out = b_in - 8'h01;
         TCAD_RR: begin // rotate through carry
            result_out = {carry_in, b_in[7:1]};
            carry_out = b_in[0];
         end
         TCAD_RL: begin
            result_out = {b_in[6:0], carry_in};
            carry_out = b_in[7];
         end
         TCAD_SWAP: result_out = {b_in[3:0], b_in[7:4]};
         TCAD_ZERO: result_out = 8'h00;
         default: result_out = b_in;
      endcase
      zero_out = (result_out == 8'h00);
   end
endmodule

// *** rtl/tcad_core.sv ***
// holds the 8-bit core: fetch stage, execute stage, working register, special registers
// assumes program memory and file memory answer reads combinationally in the same cycle
`timescale 1ns/1ps
module tcad_core
   import tcad_pkg::*;
#(
   parameter int PC_W = 9
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic master_clear_en_in,
   input wire logic master_clear_n_in,
   output logic [PC_W-1:0] prog_addr_out,
   input wire logic [tcad_pkg::INSTR_W-1:0] prog_data_in,
   output logic [tcad_pkg::FADDR_W-1:0] file_rd_addr_out,
   input wire logic [tcad_pkg::DATA_W-1:0] file_rd_data_in,
   output logic file_wr_en_out,
   output logic [tcad_pkg::FADDR_W-1:0] file_wr_addr_out,
   output logic [tcad_pkg::DATA_W-1:0] file_wr_data_out
);
   import tcad_pkg::*;

   if (PC_W < 9 || PC_W > 12) begin : g_check
      $error("tcad_core: PC_W must lie between 9 and 12");
   end

   // ****************************************
   // helpers
   // ****************************************
   // resolve a file field, address 0 going through the pointer
   function automatic logic [4:0] file_addr(input logic [4:0] f, input logic [4:0] ptr);
      file_addr = (f == ADDR_INDIRECT) ? ptr : f;
   endfunction

   // byte-oriented operations selected by instruction bits 9:6
   function automatic tcad_alu_op_type byte_op(input logic [3:0] code);
      case (code)
         4'h2: byte_op = TCAD_SUB;
         4'h3, 4'hB: byte_op = TCAD_DEC;
         4'h4: byte_op = TCAD_OR;
         4'h5: byte_op = TCAD_AND;
         4'h6: byte_op = TCAD_XOR;
         4'h7: byte_op = TCAD_ADD;
         4'h9: byte_op = TCAD_COM;
         4'hA, 4'hF: byte_op = TCAD_INC;
         4'hC: byte_op = TCAD_RR;
         4'hD: byte_op = TCAD_RL;
         4'hE: byte_op = TCAD_SWAP;
         default: byte_op = TCAD_PASS_B;
      endcase
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [PC_W-1:0] pc, next_pc;
   logic [INSTR_W-1:0] ir, next_ir;
   logic ir_valid, next_ir_valid;
   logic [DATA_W-1:0] w, next_w;
   logic [DATA_W-1:0] status, next_status;
   logic [4:0] fsr, next_fsr;
   logic [PC_W-1:0] stack [STACK_DEPTH];
   logic [PC_W-1:0] next_stack [STACK_DEPTH];
   logic [4:0] rd_addr, next_rd_addr;
   logic wr_en, next_wr_en;
   logic [4:0] wr_addr, next_wr_addr;
   logic [DATA_W-1:0] wr_data, next_wr_data;

   logic core_reset;
   logic [DATA_W-1:0] f_val, mask, alu_a, alu_b, res;
   tcad_alu_op_type op;
   logic alu_c, alu_digit, alu_z;
   logic to_w, to_f, set_c, set_digit, set_z, skip, jump;
   logic [PC_W-1:0] target;

   // master clear only counts when the shared pin is set up for it
   assign core_reset = rst_in || (master_clear_en_in && !master_clear_n_in);

   // ****************************************
   // operand read
   // ****************************************
   // special registers come from inside, others from the file with write forwarding
   always_comb begin
      if (rd_addr == ADDR_INDIRECT) begin
         f_val = 8'h00; // pointer at itself reads zero
      end else if (rd_addr == ADDR_PCL) begin
         f_val = pc[7:0];
      end else if (rd_addr == ADDR_STATUS) begin
         f_val = status;
      end else if (rd_addr == ADDR_FSR) begin
         f_val = {FSR_UPPER_READ, fsr};
      end else if (wr_en && wr_addr == rd_addr) begin
         f_val = wr_data; // write still in flight
      end else begin
         f_val = file_rd_data_in;
      end
   end

   // two's complement unit; on subtract both carry flags mean no borrow
   tcad_alu u_alu (.op_in(op), .a_in(alu_a), .b_in(alu_b), .carry_in(status[STATUS_C]),
      .result_out(res), .carry_out(alu_c), .digit_carry_out(alu_digit),
      .zero_out(alu_z));

   // ****************************************
   // decode
   // ****************************************
   // picks the operation, operands, destination and flag updates of the word in ir
   always_comb begin
      mask = 8'h01 << ir[7:5];
      op = TCAD_PASS_B;
      alu_a = w;
      alu_b = f_val;
      to_w = 1'b0;
      to_f = 1'b0;
      set_c = 1'b0;
      set_digit = 1'b0;
      set_z = 1'b0;
      skip = 1'b0;
      jump = 1'b0;
      target = pc;
      casez (ir)
         12'b0000_001?_????: begin // w to file
            op = TCAD_PASS_A;
            to_f = 1'b1;
         end
         12'b0000_0100_0000: begin // clear w
            op = TCAD_ZERO;
            to_w = 1'b1;
            set_z = 1'b1;
         end
         12'b0000_011?_????: begin // clear file
            op = TCAD_ZERO;
            to_f = 1'b1;
            set_z = 1'b1;
         end
         12'b0000_0???_????: op = TCAD_PASS_B; // no operation and control words
         12'b00??_????_????: begin // byte ops on a file
            op = byte_op(ir[9:6]);
            to_w = !ir[5];
            to_f = ir[5];
            set_c = (ir[9:6] == 4'h2) || (ir[9:6] == 4'h7) || (ir[9:7] == 3'b110);
            set_digit = (ir[9:6] == 4'h2) || (ir[9:6] == 4'h7);
            set_z = !set_c || set_digit;
            if (ir[9:6] == 4'hB || ir[9:6] == 4'hF || ir[9:6] == 4'hE) begin
               set_z = 1'b0;
            end
            skip = (ir[9:6] == 4'hB || ir[9:6] == 4'hF) && alu_z;
         end
         12'b0100_????_????: begin // clear one bit
            op = TCAD_AND;
            alu_a = ~mask;
            to_f = 1'b1;
         end
         12'b0101_????_????: begin // set one bit
            op = TCAD_OR;
            alu_a = mask;
            to_f = 1'b1;
         end
         12'b0110_????_????: skip = (f_val & mask) == 8'h00;
         12'b0111_????_????: skip = (f_val & mask) != 8'h00;
         12'b1000_????_????: begin // return with literal
            alu_b = ir[7:0];
            to_w = 1'b1;
            jump = 1'b1;
            target = stack[0];
         end
         12'b1001_????_????: begin // call
            jump = 1'b1;
            target = PC_W'({1'b0, ir[7:0]});
         end
         12'b101?_????_????: begin // goto
            jump = 1'b1;
            target = PC_W'(ir[8:0]);
         end
         default: begin // literal ops with w
            alu_b = ir[7:0];
            to_w = 1'b1;
            set_z = (ir[9:8] != 2'b00);
            case (ir[9:8])
               2'b01: op = TCAD_OR;
               2'b10: op = TCAD_AND;
               2'b11: op = TCAD_XOR;
               default: op = TCAD_PASS_B;
            endcase
         end
      endcase
   end

   // ****************************************
   // execute and fetch
   // ****************************************
   // one word retires per cycle while the next one is fetched
   always_comb begin
      next_pc = pc + PC_W'(1);
      next_ir = prog_data_in;
      next_ir_valid = 1'b1;
      next_w = w;
      next_status = status;
      next_fsr = fsr;
      next_stack = stack;
      next_wr_en = 1'b0;
      next_wr_addr = rd_addr;
      next_wr_data = res;
      if (ir_valid) begin
         next_w = to_w ? res : w;
         if (to_f) begin
            if (rd_addr == ADDR_PCL) begin
               next_pc = PC_W'({1'b0, res}); // computed jump through the file map
               next_ir_valid = 1'b0;
            end else if (rd_addr == ADDR_STATUS) begin
               next_status = (res & ~STATUS_RO_MASK) | (status & STATUS_RO_MASK);
            end else if (rd_addr == ADDR_FSR) begin
               next_fsr = res[4:0];
            end else if (rd_addr != ADDR_INDIRECT) begin
               next_wr_en = 1'b1;
            end
         end
         // flags land after any direct write to status
         next_status[STATUS_C] = set_c ? alu_c : next_status[STATUS_C];
         next_status[STATUS_DIGIT] = set_digit ? alu_digit : next_status[STATUS_DIGIT];
         next_status[STATUS_Z] = set_z ? alu_z : next_status[STATUS_Z];
         if (ir[11:8] == 4'b1001) begin
            next_stack[1] = stack[0];
            next_stack[0] = pc;
         end else if (ir[11:8] == 4'b1000) begin
            next_stack[0] = stack[1];
         end
         if (jump) begin
            next_pc = target;
            next_ir_valid = 1'b0;
         end else if (skip) begin
            next_ir_valid = 1'b0;
         end
      end
      // operand address of the incoming word, uses the pointer as it will be
      next_rd_addr = file_addr(prog_data_in[4:0], next_fsr);
   end

   // registers every piece of core state
   always_ff @(posedge clock_in) begin
      if (core_reset) begin
         pc <= '0;
         ir <= NOP_WORD;
         ir_valid <= 1'b0;
         w <= W_RESET;
         status <= STATUS_RESET;
         fsr <= FSR_RESET;
         stack <= '{default: '0};
         rd_addr <= ADDR_INDIRECT;
         wr_en <= 1'b0;
         wr_addr <= ADDR_INDIRECT;
         wr_data <= 8'h00;
      end else begin
         pc <= next_pc;
         ir <= next_ir;
         ir_valid <= next_ir_valid;
         w <= next_w;
         status <= next_status;
         fsr <= next_fsr;
         stack <= next_stack;
         rd_addr <= next_rd_addr;
         wr_en <= next_wr_en;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prog_addr_out = pc;
   assign file_rd_addr_out = rd_addr;
   assign file_wr_en_out = wr_en;
   assign file_wr_addr_out = wr_addr;
   assign file_wr_data_out = wr_data;
endmodule

// *** sim/tcad_core_sva.sv ***
// concurrent checks on the ports of the core
// assumes binding to tcad_core, one clock domain, reset from rst_in or the master clear pin
`timescale 1ns/1ps
module tcad_core_sva
   import tcad_pkg::*;
#(
   parameter int PC_W = 9
)
(
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic master_clear_en_in,
   input wire logic master_clear_n_in,
   input wire logic [PC_W-1:0] prog_addr_out,
   input wire logic [tcad_pkg::INSTR_W-1:0] prog_data_in,
   input wire logic [tcad_pkg::FADDR_W-1:0] file_rd_addr_out,
   input wire logic [tcad_pkg::DATA_W-1:0] file_rd_data_in,
   input wire logic file_wr_en_out,
   input wire logic [tcad_pkg::FADDR_W-1:0] file_wr_addr_out,
   input wire logic [tcad_pkg::DATA_W-1:0] file_wr_data_out
);
   import tcad_pkg::*;

   // ********
   // word classes that never branch
   // ********
   logic rst_any;
   logic ext_store;
   logic quiet;
   // reset as the core sees it, and words that cannot move the program counter
   assign rst_any = rst_in | (master_clear_en_in & ~master_clear_n_in);
   assign ext_store = (prog_data_in[11:5] == 7'h01) && (prog_data_in[4:0] > 5'h04);
   assign quiet = (prog_data_in[11:10] == 2'b11) || ext_store;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_any);
   // a store to an external file behind a non-branching word
   sequence s_store;
      quiet ##1 ext_store;
   endsequence
   sequence s_lit_store;
      quiet ##1 (prog_data_in[11:8] == 4'hC) ##1 ext_store;
   endsequence
   sequence s_goto;
      quiet ##1 (prog_data_in[11:9] == 3'b101);
   endsequence
   a_reset_state: assert property (disable iff (1'b0)
      rst_any |=> (prog_addr_out == '0) && !file_wr_en_out && (file_rd_addr_out == 5'h00))
      else $error("core not cleared by reset");
   a_first_fetch: assert property ($past(rst_any) |->
      (prog_addr_out == '0) ##1 (prog_addr_out == PC_W'(1)))
      else $error("fetch does not start at address zero");
   a_pc_step: assert property (quiet |=> ##1
      (prog_addr_out == PC_W'($past(prog_addr_out) + 1)))
      else $error("program counter did not step by one");
   a_goto_target: assert property (s_goto |-> ##2
      (!file_wr_en_out && (prog_addr_out == PC_W'($past(prog_data_in[8:0], 2)))))
      else $error("jump target wrong or late");
   a_operand_read: assert property (s_store |-> ##1
      (file_rd_addr_out == $past(prog_data_in[4:0])))
      else $error("operand address wrong");
   a_store_write: assert property (s_store |-> ##2
      (file_wr_en_out && (file_wr_addr_out == $past(prog_data_in[4:0], 2))))
      else $error("store did not reach the file bus");
   a_literal_data: assert property (s_lit_store |-> ##2
      (file_wr_data_out == $past(prog_data_in[7:0], 3)))
      else $error("stored data differs from literal");
   a_wr_external: assert property (file_wr_en_out |->
      !(file_wr_addr_out inside {5'h00, 5'h02, 5'h03, 5'h04}))
      else $error("internal register written on the file bus");
endmodule

bind tcad_core tcad_core_sva #(.PC_W(PC_W)) chk (.clock_in(clock_in), .rst_in(rst_in),
   .master_clear_en_in(master_clear_en_in), .master_clear_n_in(master_clear_n_in),
   .prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in),
   .file_rd_addr_out(file_rd_addr_out), .file_rd_data_in(file_rd_data_in),
   .file_wr_en_out(file_wr_en_out), .file_wr_addr_out(file_wr_addr_out),
   .file_wr_data_out(file_wr_data_out));

// *** sim/tcad_mem_model.sv ***
// program memory and file memory facing the core
// assumes reads answer combinationally and the bench loads the program directly
`timescale 1ns/1ps
module tcad_mem_model
   import tcad_pkg::*;
#(
   parameter int PC_W = 9
)
(
   input wire logic clock_in,
   input wire logic [PC_W-1:0] prog_addr_in,
   output logic [tcad_pkg::INSTR_W-1:0] prog_data_out,
   input wire logic [tcad_pkg::FADDR_W-1:0] file_rd_addr_in,
   output logic [tcad_pkg::DATA_W-1:0] file_rd_data_out,
   input wire logic file_wr_en_in,
   input wire logic [tcad_pkg::FADDR_W-1:0] file_wr_addr_in,
   input wire logic [tcad_pkg::DATA_W-1:0] file_wr_data_in
);
   import tcad_pkg::*;

   // ********
   // storage
   // ********
   logic [tcad_pkg::INSTR_W-1:0] rom [2**PC_W];
   logic [tcad_pkg::DATA_W-1:0] ram [32];
   // two independent buses, both answered within the cycle
   assign prog_data_out = rom[prog_addr_in];
   assign file_rd_data_out = ram[file_rd_addr_in];
   // a file write lands at the edge ending its cycle
   always @(posedge clock_in) begin
      if (file_wr_en_in) begin
         ram[file_wr_addr_in] <= file_wr_data_in;
      end
   end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the core with its memory model
// assumes programs are loaded into the model before each reset
`timescale 1ns/1ps
module testbench;
   import tcad_pkg::*;
   localparam int PC_W = 9;
   typedef logic [11:0] tcad_prog_type [16];
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic master_clear_en = 1'b0;
   logic master_clear_n = 1'b1;
   logic [PC_W-1:0] prog_addr;
   logic [INSTR_W-1:0] prog_data;
   logic [FADDR_W-1:0] rd_addr;
   logic [FADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] wr_data;
   logic wr_en;
   int miscompares = 0;
   int n_tests = 0;
   // 20 MHz core clock
   always #25 clock_in = ~clock_in;
   tcad_core #(.PC_W(PC_W)) dut (.clock_in(clock_in), .rst_in(rst_in),
      .master_clear_en_in(master_clear_en), .master_clear_n_in(master_clear_n),
      .prog_addr_out(prog_addr), .prog_data_in(prog_data), .file_rd_addr_out(rd_addr),
      .file_rd_data_in(rd_data), .file_wr_en_out(wr_en), .file_wr_addr_out(wr_addr),
      .file_wr_data_out(wr_data));
   tcad_mem_model #(.PC_W(PC_W)) mem (.clock_in(clock_in), .prog_addr_in(prog_addr),
      .prog_data_out(prog_data), .file_rd_addr_in(rd_addr), .file_rd_data_out(rd_data),
      .file_wr_en_in(wr_en), .file_wr_addr_in(wr_addr), .file_wr_data_in(wr_data));
   // ********
   // shared tasks
   // ********
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic load(input tcad_prog_type p);
      for (int i = 0; i < 2**PC_W; i++) begin
         mem.rom[i] = NOP_WORD;
      end
      for (int i = 0; i < 16; i++) begin
         mem.rom[i] = p[i];
      end
   endtask
   // reset for 12 cycles, released at a falling edge
   task automatic restart;
      @(negedge clock_in);
      rst_in = 1'b1;
      repeat (12) @(negedge clock_in);
      rst_in = 1'b0;
   endtask
   // bounded wait for the spin address, then let the last store land
   task automatic wait_pc(input logic [PC_W-1:0] a);
      int k;
      for (k = 0; k < 60 && prog_addr !== a; k++) begin
         @(negedge clock_in);
      end
      if (k == 60) begin
         miscompares++;
         $display("[ERR] %0t program counter never reached %h", $time, a);
         tally_and_finish();
      end
      repeat (4) @(negedge clock_in);
   endtask
   // ********
   // scenarios
   // ********
   task automatic test_alu;
      load('{12'hC3A, 12'h030, 12'hCC9, 12'h1F0, 12'h203, 12'h031, 12'hC05, 12'h0B0,
         12'h203, 12'h032, 12'h090, 12'h033, 12'h1B3, 12'h203, 12'h034, 12'hA0F});
      restart();
      wait_pc(9'h00F);
      check(12'(mem.ram[16]), 12'h0FE);
      check(12'(mem.ram[17]), 12'(STATUS_RESET | 8'h03));
      check(12'(mem.ram[18]), 12'(STATUS_RESET));
      check(12'(mem.ram[19]), 12'h000);
      check(12'(mem.ram[20]), 12'(STATUS_RESET | 8'h07));
   endtask
   task automatic test_branch;
      load('{12'hC15, 12'h024, 12'hC81, 12'h020, 12'h320, 12'h355, 12'h036, 12'hA0A,
         12'h037, 12'h000, 12'hC0E, 12'h022, 12'h038, 12'h000, 12'h039, 12'hA0F});
      mem.ram[23] = 8'h5A;
      mem.ram[24] = 8'h5A;
      restart();
      wait_pc(9'h00F);
      check(12'(mem.ram[21]), 12'h040);
      check(12'(mem.ram[22]), 12'h081);
      check(12'(mem.ram[23]), 12'h05A);
      check(12'(mem.ram[24]), 12'h05A);
      check(12'(mem.ram[25]), 12'h00E);
   endtask
   // call and return with literal, bit set, skip on set bit, nibble swap, increment
   task automatic test_call;
      load('{12'hC5A, 12'hFFF, 12'h90C, 12'h03D, 12'h51D, 12'h71D, 12'h07D, 12'h39D,
         12'h2BE, 12'h03F, 12'hA0F, 12'h000, 12'h03E, 12'h83C, 12'h000, 12'hA0F});
      restart();
      wait_pc(9'h00F);
      check(12'(mem.ram[29]), 12'h03D);
      check(12'(mem.ram[30]), 12'h0A6);
      check(12'(mem.ram[31]), 12'h0D3);
   endtask
   // decrement and skip on zero, complement, literal logic, bit clear, skip on clear bit
   task automatic test_bits;
      load('{12'hC02, 12'h025, 12'h2E5, 12'h2E5, 12'h026, 12'h245, 12'hEF0, 12'h027,
         12'h4E7, 12'h6E7, 12'h026, 12'hD0F, 12'h028, 12'h040, 12'h029, 12'hA0F});
      mem.ram[6] = 8'h77;
      mem.ram[9] = 8'h55;
      restart();
      wait_pc(9'h00F);
      check(12'(mem.ram[5]), 12'h000);
      check(12'(mem.ram[6]), 12'h077);
      check(12'(mem.ram[7]), 12'h070);
      check(12'(mem.ram[8]), 12'h0FF);
      check(12'(mem.ram[9]), 12'h000);
   endtask
   task automatic test_master_clear_n;
      logic [PC_W-1:0] seq [10] = '{9'h000, 9'h001, 9'h002, 9'h003, 9'h004, 9'h005,
         9'h006, 9'h007, 9'h000, 9'h001};
      load('{12'hC11, 12'h03A, 12'hC22, 12'h03B, 12'hC33, 12'h03C, 12'hA00, 12'h000,
         12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000});
      restart();
      for (int k = 0; k < 10; k++) begin
         check(12'(prog_addr), 12'(seq[k]));
         @(negedge clock_in);
      end
      repeat (4) @(negedge clock_in);
      check(12'(mem.ram[27]), 12'h022);
      check(12'(mem.ram[28]), 12'h033);
      // pin low while it acts as master clear
      master_clear_en = 1'b1;
      master_clear_n = 1'b0;
      @(negedge clock_in);
      mem.ram[26] = 8'h00;
      repeat (8) @(negedge clock_in);
      check(12'(prog_addr), 12'h000);
      check(12'(mem.ram[26]), 12'h000);
      // same pin level with the function off must not reset
      master_clear_en = 1'b0;
      repeat (12) @(negedge clock_in);
      check(12'(mem.ram[26]), 12'h011);
      master_clear_n = 1'b1;
   endtask
   initial begin
      test_alu();
      test_branch();
      test_call();
      test_bits();
      test_master_clear_n();
      tally_and_finish();
   end
endmodule
